// *** hw/usr_top.sv ***
/*
  Suspend and resume controller of a hub with embedded function and core.
  Detects global suspend, gates clocks once the core sleeps, handles host
  resume, downstream remote wakeup and function wakeup.
  Assumes all inputs synchronous to clk; firmware clears flags by pulses.
*/
`timescale 1ns/1ps
`include "usr_params.svh"
module usr_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // upstream line state
  input  wire logic                  up_idle,
  input  wire logic                  up_j,
  input  wire logic                  up_k,
  // downstream and function wake sources
  input  wire logic                  ds_wakeup,
  input  wire logic                  ext_irq_a,
  input  wire logic                  ext_irq_b,
  // core status
  input  wire logic                  core_asleep,
  // firmware flag control
  input  wire logic                  susp_irq_en,
  input  wire logic                  clr_global_suspend,
  input  wire logic                  clr_resume,
  input  wire logic                  clr_function_wakeup,
  input  wire logic [`USR_PORTS-1:0] clr_port_susp_chg,
  // status flags
  output logic                       global_suspend_flag,
  output logic                       resume_flag,
  output logic                       function_wakeup_flag,
  output logic [`USR_PORTS-1:0]      port_susp_chg,
  output usr_pkg::usr_src_t          wake_source,
  output logic                       core_irq,
  // clocks and signaling
  output logic                       osc_en,
  output logic                       pll_en,
  output logic                       ds_signal_en,
  output logic                       ds_resume_drive,
  output logic                       up_resume_drive,
  output logic                       usb_active
);
  import usr_pkg::*;
  // loaded one short: the state moves on at the edge after the count hits zero
  localparam usr_cnt_t RESUME_CYC = usr_cnt_t'(`USR_RESUME_CYC - 1);
  localparam usr_cnt_t CLKUP_CYC  = usr_cnt_t'(`USR_CLK_START_CYC - 1);

  usr_state_t state_q;
  usr_state_t state_d;
  usr_src_t   src_q;
  logic       j_seen_q;
  logic       idle_hit;
  logic       wake_host;
  logic       wake_port;
  logic       wake_func;
  logic       wake_any;
  logic       clk_off_q;
  logic       resume_end;

  usr_tmr_if  tmr ();

  usr_idle_det u_idle (
    .clk      (clk),
    .rst      (rst),
    .bus_idle (up_idle),
    .arm      (state_q == USR_RUN),
    .idle_hit (idle_hit)
  );

  usr_timer u_tmr (
    .clk (clk),
    .rst (rst),
    .t   (tmr)
  );

  // wake sources, only meaningful while suspended
  assign wake_host = j_seen_q && up_k;
  assign wake_port = ds_wakeup;
  assign wake_func = ext_irq_a || ext_irq_b;
  assign wake_any  = (state_q == USR_SUSP) &&
                     (wake_host || wake_port || wake_func);

  // remembers J so that the next K marks the J to K change
  always_ff @(posedge clk) begin
    if (rst || state_q != USR_SUSP) begin
      j_seen_q <= 1'b0;
    end else if (up_j) begin
      j_seen_q <= 1'b1;
    end else if (up_k) begin
      j_seen_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      USR_RUN: begin
        if (idle_hit) begin
          state_d = USR_QUIET;
        end
      end
      USR_QUIET: begin
        state_d = USR_SUSP;
      end
      USR_SUSP: begin
        if (wake_any) begin
          state_d = USR_CLKUP;
        end
      end
      USR_CLKUP: begin
        if (tmr.done) begin
          state_d = USR_RESUME;
        end
      end
      USR_RESUME: begin
        if (tmr.done) begin
          state_d = USR_RUN;
        end
      end
      default: begin
        state_d = USR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= USR_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // timer loads: clock start-up, then resume signaling length
  assign tmr.load = (wake_any) ||
                    (state_q == USR_CLKUP && tmr.done);
  assign tmr.load_val = (state_q == USR_CLKUP) ? RESUME_CYC : CLKUP_CYC;
  assign resume_end = (state_q == USR_RESUME) && tmr.done;

  // wake source is captured at the wake event
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= USR_SRC_NONE;
    end else if (wake_any) begin
      if (wake_host) begin
        src_q <= USR_SRC_HOST;
      end else if (wake_port) begin
        src_q <= USR_SRC_PORT;
      end else begin
        src_q <= USR_SRC_FUNC;
      end
    end
  end

  // clock gating: off only after the core sleeps while suspended
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_off_q <= 1'b0;
    end else if (wake_any) begin
      clk_off_q <= 1'b0;
    end else if (state_q == USR_SUSP && core_asleep) begin
      clk_off_q <= 1'b1;
    end
  end

  // global suspend flag: set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      global_suspend_flag <= 1'b0;
    end else if (state_q == USR_QUIET) begin
      global_suspend_flag <= 1'b1;
    end else if (clr_global_suspend) begin
      global_suspend_flag <= 1'b0;
    end
  end

  // resume flag set on any wake, held until firmware clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      resume_flag <= 1'b0;
    end else if (wake_any) begin
      resume_flag <= 1'b1;
    end else if (clr_resume) begin
      resume_flag <= 1'b0;
    end
  end

  // function wakeup flag for external interrupt wakes
  always_ff @(posedge clk) begin
    if (rst) begin
      function_wakeup_flag <= 1'b0;
    end else if (wake_any && !wake_host && !wake_port) begin
      function_wakeup_flag <= 1'b1;
    end else if (clr_function_wakeup) begin
      function_wakeup_flag <= 1'b0;
    end
  end

  // per-port suspend status change bits
  genvar gi;
  generate
    for (gi = 0; gi < `USR_PORTS; gi = gi + 1) begin : g_port
      always_ff @(posedge clk) begin
        if (rst) begin
          port_susp_chg[gi] <= 1'b0;
        end else if (resume_end) begin
          port_susp_chg[gi] <= 1'b1;
        end else if (clr_port_susp_chg[gi]) begin
          port_susp_chg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // resume flag always interrupts; suspend flag only when enabled
  // core wakes, continues, then sees this level pending
  assign core_irq = resume_flag || function_wakeup_flag ||
                    (global_suspend_flag && susp_irq_en);

  assign osc_en          = !clk_off_q;
  assign pll_en          = !clk_off_q;
  assign ds_signal_en    = (state_q == USR_RUN) ||
                           (state_q == USR_RESUME && src_q == USR_SRC_HOST);
  assign ds_resume_drive = (state_q == USR_RESUME) &&
                           (src_q == USR_SRC_HOST);
  assign up_resume_drive = (state_q == USR_RESUME) &&
                           (src_q != USR_SRC_HOST);
  assign usb_active      = (state_q == USR_RUN) ||
                           (state_q == USR_RESUME);
  assign wake_source     = src_q;
endmodule : usr_top

// *** hw/usr_params.svh ***
/*
  Constants of the suspend/resume controller: timing counts, flag positions,
  reset values.
  Assumes a 40 MHz clock; included by bare name.
*/
// Notes on behaviour
// - Upstream idle for at least 3 ms is the only cause of global suspend.
// - Suspend sets the global suspend flag; interrupt only when enabled.
// - Downstream signaling stops before the global suspend flag is raised.
// - Once the core sleeps during suspend, oscillator and PLL stop.
// - Upstream J to K restarts clocks and drives resume downstream.
// - Any resume sets the resume flag, which interrupts the core.
// - Downstream remote wakeup restarts clocks, resumes upstream, sets flag.
// - Either external interrupt during suspend wakes clocks and USB logic.
// - Function wakeup drives resume upstream, sets wakeup and resume flags.
// - Core resumes after its sleep point, then takes the resume interrupt.
// - End of resume signaling sets the port suspend status change bits.
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH
`define USR_CLK_KHZ         40000
`define USR_IDLE_US         3000
`define USR_IDLE_CYC        ((`USR_IDLE_US * `USR_CLK_KHZ + 999) / 1000)
`define USR_RESUME_US       20000
`define USR_RESUME_CYC      ((`USR_RESUME_US * `USR_CLK_KHZ + 999) / 1000)
`define USR_CLK_START_CYC   16
`define USR_CNT_W           20
`define USR_FLAG_SUSP       0
`define USR_FLAG_RSM        1
`define USR_FLAG_FWUP       2
`define USR_FLAGS_RST       3'h0
`define USR_PORTS           2
`endif

// *** hw/usr_pkg.sv ***
/*
  Types of the suspend/resume controller.
  Assumes usr_params.svh is on the include path.
*/
`include "usr_params.svh"
package usr_pkg;
  typedef enum logic [2:0] {
    USR_RUN     = 3'h0,
    USR_QUIET   = 3'h1,
    USR_SUSP    = 3'h2,
    USR_CLKUP   = 3'h3,
    USR_RESUME  = 3'h4
  } usr_state_t;
  typedef enum logic [1:0] {
    USR_SRC_NONE = 2'h0,
    USR_SRC_HOST = 2'h1,
    USR_SRC_PORT = 2'h2,
    USR_SRC_FUNC = 2'h3
  } usr_src_t;
  typedef logic [`USR_CNT_W-1:0] usr_cnt_t;
endpackage : usr_pkg

// *** hw/usr_tmr_if.sv ***
/*
  Timer handshake between the controller and its shared down counter.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface usr_tmr_if;
  usr_pkg::usr_cnt_t load_val;
  logic              load;
  logic              done;
  modport ctrl (output load_val, output load, input done);
  modport tmr  (input load_val, input load, output done);
endinterface : usr_tmr_if

// *** hw/usr_timer.sv ***
/*
  Loadable down counter; done is high once the loaded count has run out.
  Assumes synchronous active high reset.
*/
`timescale 1ns/1ps
module usr_timer (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // control side
  usr_tmr_if.tmr     t
);
  import usr_pkg::*;
  usr_cnt_t cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (t.load) begin
      cnt_q <= t.load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - usr_cnt_t'(1);
    end
  end
  // done must not look at load: load is formed from done on the control side
  assign t.done = (cnt_q == '0);
endmodule : usr_timer

// *** hw/usr_idle_det.sv ***
/*
  Upstream idle detector: pulses once after continuous idle for the count.
  Assumes idle input is synchronous to clk.
*/
`timescale 1ns/1ps
`include "usr_params.svh"
module usr_idle_det (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // bus state
  input  wire logic  bus_idle,
  input  wire logic  arm,
  output logic       idle_hit
);
  import usr_pkg::*;
  localparam usr_cnt_t IDLE_CYC = usr_cnt_t'(`USR_IDLE_CYC);
  usr_cnt_t cnt_q;
  // any activity restarts the count
  always_ff @(posedge clk) begin
    if (rst || !bus_idle || !arm) begin
      cnt_q <= '0;
    end else if (cnt_q != IDLE_CYC) begin
      cnt_q <= cnt_q + usr_cnt_t'(1);
    end
  end
  assign idle_hit = arm && bus_idle && (cnt_q == IDLE_CYC - usr_cnt_t'(1));
endmodule : usr_idle_det

// *** bench/usr_top_assertions.sv ***
/*
  Checker of the suspend/resume controller ports, bound to usr_top.
  Assumes usr_params.svh on the include path and one clock domain.
*/
`timescale 1ns/1ps
`include "usr_params.svh"
module usr_chk
  import usr_pkg::*;
(
  // clock, reset and inputs
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  up_idle,
  input wire logic                  up_k,
  input wire logic                  ds_wakeup,
  input wire logic                  ext_irq_a,
  input wire logic                  ext_irq_b,
  input wire logic                  core_asleep,
  input wire logic                  susp_irq_en,
  input wire logic                  clr_resume,
  // outputs watched
  input wire logic                  global_suspend_flag,
  input wire logic                  resume_flag,
  input wire logic                  function_wakeup_flag,
  input wire logic [`USR_PORTS-1:0] port_susp_chg,
  input wire usr_pkg::usr_src_t     wake_source,
  input wire logic                  core_irq,
  input wire logic                  osc_en,
  input wire logic                  pll_en,
  input wire logic                  ds_signal_en,
  input wire logic                  ds_resume_drive,
  input wire logic                  up_resume_drive
);
  import usr_pkg::*;
  localparam int IDLE = `USR_IDLE_CYC;
  localparam int RESUME_FLAG  = `USR_RESUME_CYC;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int  idle_q;
  int  drv_q;
  wire drv = ds_resume_drive | up_resume_drive;
  // run lengths of upstream idle and of resume drive
  always_ff @(posedge clk) begin
    idle_q <= (rst || !up_idle) ? 0 : idle_q + 1;
  end
  always_ff @(posedge clk) begin
    drv_q <= (rst || !drv) ? 0 : drv_q + 1;
  end
  AST_SUSP_IDLE: assert property ($rose(global_suspend_flag) |->
    idle_q >= IDLE) else $error("suspend without enough idle");
  AST_DS_STOP: assert property ($rose(global_suspend_flag) |->
    !$past(ds_signal_en)) else $error("downstream not stopped first");
  AST_IRQ: assert property (core_irq == (resume_flag |
    function_wakeup_flag | (global_suspend_flag & susp_irq_en)))
    else $error("interrupt mismatch");
  AST_CLK_OFF: assert property (global_suspend_flag && core_asleep
    && osc_en && !resume_flag |=> !osc_en && !pll_en)
    else $error("clocks not stopped");
  AST_WAKE: assert property (!osc_en && (up_k | ds_wakeup |
    ext_irq_a | ext_irq_b) |=> osc_en && pll_en && resume_flag)
    else $error("wake missed");
  AST_FUNC: assert property ($rose(function_wakeup_flag) |->
    resume_flag && wake_source == USR_SRC_FUNC)
    else $error("function wake flags wrong");
  AST_START: assert property ($rose(drv) |->
    $past(osc_en, 16) && !$past(osc_en, 17))
    else $error("resume drive start wrong");
  AST_RSM_LEN: assert property ($fell(drv) |->
    drv_q == RESUME_FLAG && port_susp_chg == 2'h3)
    else $error("resume length or port change wrong");
  AST_DIR: assert property (ds_resume_drive |->
    wake_source == USR_SRC_HOST && !up_resume_drive)
    else $error("resume direction wrong");
  AST_HOLD: assert property (resume_flag && !clr_resume |=>
    resume_flag) else $error("resume flag lost");
endmodule : usr_chk
bind usr_top usr_chk u_chk (
  .clk                  (clk),
  .rst                  (rst),
  .up_idle              (up_idle),
  .up_k                 (up_k),
  .ds_wakeup            (ds_wakeup),
  .ext_irq_a            (ext_irq_a),
  .ext_irq_b            (ext_irq_b),
  .core_asleep          (core_asleep),
  .susp_irq_en          (susp_irq_en),
  .clr_resume           (clr_resume),
  .global_suspend_flag  (global_suspend_flag),
  .resume_flag          (resume_flag),
  .function_wakeup_flag (function_wakeup_flag),
  .port_susp_chg        (port_susp_chg),
  .wake_source          (wake_source),
  .core_irq             (core_irq),
  .osc_en               (osc_en),
  .pll_en               (pll_en),
  .ds_signal_en         (ds_signal_en),
  .ds_resume_drive      (ds_resume_drive),
  .up_resume_drive      (up_resume_drive)
);

// *** bench/usr_host_model.sv ***
/*
  Upstream host model: line state of the upstream port.
  Assumes mode changes just after a rising clk edge.
*/
`timescale 1ns/1ps
module usr_host_model (
  // clock and command: 0 traffic, 1 idle, 2 resume
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  // upstream line state
  output logic            up_idle,
  output logic            up_j,
  output logic            up_k
);
  logic ph_q = 1'b0;
  always_ff @(posedge clk) begin
    ph_q <= ~ph_q;
  end
  // traffic toggles J and K, idle parks in J, resume holds K
  always_comb begin
    up_idle = (mode == 2'h1);
    up_j    = (mode == 2'h1) || (mode == 2'h0 && ph_q);
    up_k    = (mode == 2'h2) || (mode == 2'h0 && !ph_q);
  end
endmodule : usr_host_model

// *** bench/tb_usr_top.sv ***
/*
  Bench of usr_top: host model upstream, firmware and wake sources here.
  Assumes usr_params.svh on the include path.
*/
`timescale 1ns/1ps
`include "usr_params.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_usr_top;
  import usr_pkg::*;
  localparam int IDLE = `USR_IDLE_CYC;
  localparam int RESUME_FLAG  = `USR_RESUME_CYC;
  logic       clk = 1'b0, rst = 1'b1, ds_wk = 1'b0, ext_a = 1'b0;
  logic       ext_b = 1'b0, asleep = 1'b0, irq_en = 1'b0;
  logic       clr_gs = 1'b0, clr_rs = 1'b0, clr_fw = 1'b0;
  logic [1:0] clr_pc = 2'h0, mode = 2'h0, pchg;
  logic       up_idle, up_j, up_k, gs, rs, fw, irq, osc, pll;
  logic       dse, dsd, upd, act;
  usr_src_t   src;
  int         err_count = 0, comparisons = 0, cyc = 0;
  int         seed = 32'hcda77e9e;
  always #12.5 clk = ~clk;
  usr_host_model u_host (.clk(clk), .mode(mode), .up_idle(up_idle),
    .up_j(up_j), .up_k(up_k));
  usr_top u_dut (.clk(clk), .rst(rst), .up_idle(up_idle), .up_j(up_j),
    .up_k(up_k), .ds_wakeup(ds_wk), .ext_irq_a(ext_a), .ext_irq_b(ext_b),
    .core_asleep(asleep), .susp_irq_en(irq_en), .clr_global_suspend(clr_gs),
    .clr_resume(clr_rs), .clr_function_wakeup(clr_fw),
    .clr_port_susp_chg(clr_pc), .global_suspend_flag(gs), .resume_flag(rs),
    .function_wakeup_flag(fw), .port_susp_chg(pchg), .wake_source(src),
    .core_irq(irq), .osc_en(osc), .pll_en(pll), .ds_signal_en(dse),
    .ds_resume_drive(dsd), .up_resume_drive(upd), .usb_active(act));
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4 * (IDLE + RESUME_FLAG) + 2000) begin
      err_count++;
      results();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // one suspend, sleep, wake by source s, resume and firmware clear
  task automatic run_wake(input int s);
    int         k;
    logic [1:0] ab;
    @(posedge clk);
    irq_en <= 1'($random(seed));
    mode <= 2'h1;
    k = 0;
    while (gs !== 1'b1 && k < IDLE + 8) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK("suspend delay", 1'b1, k >= IDLE && k <= IDLE + 2)
    `CHK("downstream off", 1'b0, dse)
    `CHK("suspend irq", irq_en, irq)
    @(posedge clk);
    asleep <= 1'b1;
    tick(3 + {$random(seed)} % 32);
    #1 `CHK("clocks off", 2'h0, {osc, pll})
    @(posedge clk);
    case (s)
      1: mode <= 2'h2;
      2: ds_wk <= 1'b1;
      default: begin
        ab = 2'($random(seed));
        if (ab == 2'h0) ab = 2'h3;
        ext_a <= ab[0];
        ext_b <= ab[1];
      end
    endcase
    tick(1);
    #1 `CHK("resume flag", 3'h7, {rs, osc, pll})
    `CHK("wake source", 2'(s), src)
    `CHK("func flag", s == 3, fw)
    @(posedge clk);
    {ds_wk, ext_a, ext_b, asleep, mode} <= 6'h00;
    tick(14);
    #1 `CHK("drive early", 1'b0, dsd | upd)
    tick(1);
    #1 `CHK("resume dir", (s == 1) ? 2'h2 : 2'h1, {dsd, upd})
    k = 0;
    while ((dsd | upd) !== 1'b0 && k < RESUME_FLAG + 8) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK("resume length", RESUME_FLAG, k)
    `CHK("port change", 2'h3, pchg)
    `CHK("flags held", 3'h7, {gs, rs, act})
    @(posedge clk);
    {clr_gs, clr_rs, clr_fw, clr_pc} <= 5'h1F;
    @(posedge clk);
    {clr_gs, clr_rs, clr_fw, clr_pc} <= 5'h00;
    tick(1);
    #1 `CHK("flags cleared", 6'h00, {gs, rs, fw, pchg, irq})
  endtask : run_wake
  initial begin
    tick(6);
    rst <= 1'b0;
    // idle just short of the suspend count, then traffic again
    mode <= 2'h1;
    tick(IDLE - 2 - {$random(seed)} % 64);
    mode <= 2'h0;
    tick(4);
    #1 `CHK("early suspend", 1'b0, gs)
    for (int s = 1; s < 4; s++) begin
      run_wake(s);
    end
    results();
  end
endmodule : tb_usr_top
